// *** wdsc_defs.svh ***
// register offsets, field positions, reset values and counts of the watchdog block
`ifndef WDSC_DEFS_SVH
`define WDSC_DEFS_SVH
`define WDSC_ADDR_STATUS      16'h0003
`define WDSC_ADDR_IRQCTL      16'h000b
`define WDSC_ADDR_OPTION      16'h0081
`define WDSC_ADDR_OPTION_HI   16'h0181
`define WDSC_ADDR_CONFIG      16'h2007
`define WDSC_CFG_WDT_EN_BIT   2
`define WDSC_ST_TO_BIT        4
`define WDSC_ST_PD_BIT        3
`define WDSC_CFG_RESET        8'hff
`define WDSC_OPT_RESET        8'hff
`define WDSC_IRQ_RESET        8'h00
`define WDSC_WDT_BASE_TICKS   256
`define WDSC_SCALER_W         8
`endif

// *** wdsc_pkg.sv ***
// types shared by the watchdog and sleep control block
package wdsc_pkg;
   // scaler and timer0 setup register, bit 7 down to bit 0
   typedef struct packed {
      logic       pullup_dis;
      logic       int_edge;
      logic       t0_src;
      logic       t0_edge;
      logic       scaler_owner_select;
      logic [2:0] scale_ratio;
   } wdsc_option_t;
   // interrupt control register, bit 7 down to bit 0
   typedef struct packed {
      logic global_irq_enable;
      logic periph_en;
      logic t0_en;
      logic int_en;
      logic rb_en;
      logic t0_flag;
      logic int_flag;
      logic rb_flag;
   } wdsc_irqctl_t;
   typedef enum logic {
      st_run,
      st_sleep
   } wdsc_state_t;
endpackage : wdsc_pkg

// *** wdsc_sync3.sv ***
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module wdsc_sync3 #(
   parameter logic RESET_VAL = 1'b0
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // asynchronous input and filtered level
   input  wire logic din,
   output logic      level
);
   logic s1;
   logic s2;
   logic s3;

   // stages reset to the idle level so release does not fake an edge
   always_ff @(posedge clk) begin
      if (rst) begin
         s1    <= RESET_VAL;
         s2    <= RESET_VAL;
         s3    <= RESET_VAL;
         level <= RESET_VAL;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            level <= s3;
         end
      end
   end
endmodule : wdsc_sync3

// *** wdsc_counter.sv ***
// clearable up-counter used for the watchdog base count and the shared scaler
`timescale 1ns/1ps
module wdsc_counter #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // control
   input  wire logic         clr,
   input  wire logic         inc,
   // count
   output logic [W-1:0]      cnt
);
   always_ff @(posedge clk) begin
      if (rst || clr) begin
         cnt <= '0;
      end else if (inc) begin
         cnt <= cnt + W'(1);
      end
   end
endmodule : wdsc_counter

// *** wdsc_core.sv ***
// watchdog timer, shared scaler and power-down control
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
// Overview of operation
// - watchdog counts ticks of its own RC oscillator
// - time-out while running forces device reset
// - time-out while asleep wakes without reset
// - every time-out clears the timeout flag
// - cleared enable fuse disables watchdog entirely
// - one scaler, owner select, three-bit ratio
// - clear or sleep zeroes counter and owned scaler
// - clear keeps scaler owner unchanged
// - sleep clears powerdown, sets timeout, stops oscillator
// - pins hold their drive state while asleep
// - wake on master clear, time-out, enabled interrupt
// - master clear resets, other wakes continue
// - powerdown flag set at power-up, cleared by sleep
// - only clockless peripherals may wake the device
// - clocked peripherals raise nothing while asleep
// - next instruction prefetched during sleep
// - wake needs individual enable, not global enable
// - after wake, vector only if global enable set
// - pending interrupt makes sleep a no-operation
// - interrupt during sleep completes side effects first
// - any reset clears the global interrupt enable
`include "wdsc_defs.svh"
module wdsc_core #(
   parameter int WDT_BASE_TICKS = `WDSC_WDT_BASE_TICKS,
   parameter int NUM_PERIPH     = 8
) (
   // clock and reset
   input  wire logic                  mclk,
   input  wire logic                  rst,
   // register port
   input  wire logic [15:0]           reg_addr,
   input  wire logic [7:0]            reg_wdata,
   input  wire logic                  reg_we,
   input  wire logic                  reg_re,
   output logic      [7:0]            reg_rdata,
   // instruction strobes from the core
   input  wire logic                  clear_watchdog_instr,
   input  wire logic                  sleep_instr,
   // pins
   input  wire logic                  wdt_rc_osc,
   input  wire logic                  master_clear_n,
   // interrupt sources
   input  wire logic                  t0_overflow,
   input  wire logic                  int_pin_event,
   input  wire logic                  rb_change_event,
   input  wire logic [NUM_PERIPH-1:0] periph_irq_req,
   input  wire logic [NUM_PERIPH-1:0] periph_clockless,
   // timer0 source through the shared scaler
   input  wire logic                  t0_source_evt,
   output logic                       t0_inc,
   // device control
   output logic                       device_reset,
   output logic                       wake_pulse,
   output logic                       isr_vector_req,
   output logic                       prefetch_next,
   output logic                       main_osc_run,
   output logic                       io_hold,
   output logic                       global_irq_enable,
   // status flags
   output logic                       timeout_flag_n,
   output logic                       powerdown_flag_n
);
   localparam int SW     = `WDSC_SCALER_W;
   localparam int BASE_W = (WDT_BASE_TICKS > 2) ? $clog2(WDT_BASE_TICKS) : 1;
   localparam logic [BASE_W-1:0] BASE_LAST = BASE_W'(WDT_BASE_TICKS - 1);

   // registers
   logic [7:0]             config_word;
   wdsc_pkg::wdsc_option_t opt;
   wdsc_pkg::wdsc_irqctl_t irq;
   wdsc_pkg::wdsc_state_t  state;

   // synchronised pins
   logic osc_lvl;
   logic osc_lvl_d;
   logic master_clear_n_lvl;

   // counters
   logic [BASE_W-1:0] base_cnt;
   logic [SW-1:0]     scal_cnt;

   // next values
   logic       next_device_reset;
   logic       next_wake;
   logic       next_vector;
   logic [7:0] next_rdata;

   // decode
   wire wr_config  = reg_we && (reg_addr == `WDSC_ADDR_CONFIG);
   wire wr_option  = reg_we && ((reg_addr == `WDSC_ADDR_OPTION) ||
                                (reg_addr == `WDSC_ADDR_OPTION_HI));
   wire wr_irq     = reg_we && (reg_addr == `WDSC_ADDR_IRQCTL);
   wire rd_config  = reg_addr == `WDSC_ADDR_CONFIG;
   wire rd_option  = (reg_addr == `WDSC_ADDR_OPTION) ||
                     (reg_addr == `WDSC_ADDR_OPTION_HI);
   wire rd_irq     = reg_addr == `WDSC_ADDR_IRQCTL;
   wire rd_status  = reg_addr == `WDSC_ADDR_STATUS;

   wire running    = state == wdsc_pkg::st_run;
   wire sleeping   = state == wdsc_pkg::st_sleep;

   // oscillator pin sampled into mclk; a rising edge is one tick
   wdsc_sync3 #(
      .RESET_VAL (1'b0)
   ) u_osc_sync (
      .clk   (mclk),
      .rst   (rst),
      .din   (wdt_rc_osc),
      .level (osc_lvl)
   );

   wdsc_sync3 #(
      .RESET_VAL (1'b1)
   ) u_master_clear_n_sync (
      .clk   (mclk),
      .rst   (rst),
      .din   (master_clear_n),
      .level (master_clear_n_lvl)
   );

   wire rc_tick      = osc_lvl && !osc_lvl_d;
   wire master_clear_n_active  = !master_clear_n_lvl;
   wire wdt_enabled  = config_word[`WDSC_CFG_WDT_EN_BIT];
   wire owner_wdt    = opt.scaler_owner_select;

   // interrupt sources; clocked sources fall silent while asleep
   wire t0_flag_set  = t0_overflow && !sleeping;
   wire [NUM_PERIPH-1:0] periph_live =
      periph_irq_req & (sleeping ? periph_clockless : '1);

   // wake needs only the individual enable; the global enable is not looked at
   wire irq_pending  = (irq.t0_en  && irq.t0_flag)  ||
                       (irq.int_en && irq.int_flag) ||
                       (irq.rb_en  && irq.rb_flag)  ||
                       (irq.periph_en && (|periph_live));

   // a pending interrupt turns the sleep instruction into a no-operation
   wire sleep_exec   = sleep_instr && running && !irq_pending;
   wire wd_clear     = clear_watchdog_instr || sleep_exec;

   // base period counter
   wire base_wrap    = wdt_enabled && rc_tick && (base_cnt == BASE_LAST);
   wire base_clr     = wd_clear || base_wrap || !wdt_enabled;
   wire base_inc     = wdt_enabled && rc_tick;

   wdsc_counter #(
      .W (BASE_W)
   ) u_base (
      .clk (mclk),
      .rst (rst),
      .clr (base_clr),
      .inc (base_inc),
      .cnt (base_cnt)
   );

   // shared scaler: postscaler 1:2^n for the watchdog, prescaler 1:2^(n+1) for timer0
   wire [SW-1:0] wdt_mask = SW'((SW'(1) << opt.scale_ratio) - SW'(1));
   wire [SW-1:0] t0_mask  = SW'((SW'(2) << opt.scale_ratio) - SW'(1));
   wire wdt_hit      = (scal_cnt & wdt_mask) == wdt_mask;
   wire t0_hit       = (scal_cnt & t0_mask) == t0_mask;

   // clearing the count leaves the owner select alone
   wire scal_clr     = wd_clear && owner_wdt;
   wire scal_inc     = owner_wdt ? base_wrap : t0_source_evt;

   wdsc_counter #(
      .W (SW)
   ) u_scaler (
      .clk (mclk),
      .rst (rst),
      .clr (scal_clr),
      .inc (scal_inc),
      .cnt (scal_cnt)
   );

   wire timeout      = owner_wdt ? (base_wrap && wdt_hit) : base_wrap;
   wire next_t0_inc  = owner_wdt ? t0_source_evt : (t0_source_evt && t0_hit);

   // reset request: master clear is held as a level, a time-out is one pulse
   always_comb begin
      next_device_reset = master_clear_n_active;
      if (running && timeout) begin
         next_device_reset = 1'b1;
      end
   end

   // wake: a time-out or an enabled interrupt, but not together with a master clear
   always_comb begin
      next_wake   = 1'b0;
      next_vector = 1'b0;
      if (sleeping && !master_clear_n_active) begin
         if (timeout) begin
            next_wake = 1'b1;
         end else if (irq_pending) begin
            next_wake   = 1'b1;
            next_vector = irq.global_irq_enable;
         end
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      next_rdata = 8'h00;
      if (rd_config) begin
         next_rdata = config_word;
      end else if (rd_option) begin
         next_rdata = opt;
      end else if (rd_irq) begin
         next_rdata = irq;
      end else if (rd_status) begin
         next_rdata[`WDSC_ST_TO_BIT] = timeout_flag_n;
         next_rdata[`WDSC_ST_PD_BIT] = powerdown_flag_n;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_re) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         config_word <= `WDSC_CFG_RESET;
         opt         <= wdsc_pkg::wdsc_option_t'(`WDSC_OPT_RESET);
      end else begin
         if (wr_config) begin
            config_word <= reg_wdata;
         end
         if (wr_option) begin
            opt <= wdsc_pkg::wdsc_option_t'(reg_wdata);
         end
      end
   end

   // hardware sets are written last so an event beats a software clear
   always_ff @(posedge mclk) begin
      if (rst) begin
         irq <= wdsc_pkg::wdsc_irqctl_t'(`WDSC_IRQ_RESET);
      end else begin
         if (wr_irq) begin
            irq <= wdsc_pkg::wdsc_irqctl_t'(reg_wdata);
         end
         if (next_device_reset) begin
            irq.global_irq_enable <= 1'b0;
         end
         if (t0_flag_set) begin
            irq.t0_flag <= 1'b1;
         end
         if (int_pin_event) begin
            irq.int_flag <= 1'b1;
         end
         if (rb_change_event) begin
            irq.rb_flag <= 1'b1;
         end
      end
   end

   // status flags survive device resets; only power-up sets both
   always_ff @(posedge mclk) begin
      if (rst) begin
         timeout_flag_n   <= 1'b1;
         powerdown_flag_n <= 1'b1;
      end else if (timeout) begin
         // a time-out in the same cycle as sleep still counts
         timeout_flag_n <= 1'b0;
         if (sleep_exec) begin
            powerdown_flag_n <= 1'b0;
         end
      end else if (sleep_exec) begin
         timeout_flag_n   <= 1'b1;
         powerdown_flag_n <= 1'b0;
      end
   end

   // sleep state machine
   always_ff @(posedge mclk) begin
      if (rst) begin
         state <= wdsc_pkg::st_run;
      end else begin
         case (state)
            wdsc_pkg::st_run: begin
               if (sleep_exec && !master_clear_n_active) begin
                  state <= wdsc_pkg::st_sleep;
               end
            end
            wdsc_pkg::st_sleep: begin
               if (master_clear_n_active || next_wake) begin
                  state <= wdsc_pkg::st_run;
               end
            end
            default: begin
               state <= wdsc_pkg::st_run;
            end
         endcase
      end
   end

   // outputs, each from its own flip-flop
   always_ff @(posedge mclk) begin
      if (rst) begin
         device_reset   <= 1'b0;
         wake_pulse     <= 1'b0;
         isr_vector_req <= 1'b0;
         prefetch_next  <= 1'b0;
         t0_inc         <= 1'b0;
      end else begin
         device_reset   <= next_device_reset;
         wake_pulse     <= next_wake;
         isr_vector_req <= next_vector;
         prefetch_next  <= sleep_exec;
         t0_inc         <= next_t0_inc;
      end
   end

   // oscillator driver off and pins frozen for the whole of sleep
   always_ff @(posedge mclk) begin
      if (rst) begin
         main_osc_run <= 1'b1;
         io_hold      <= 1'b0;
         osc_lvl_d    <= 1'b0;
      end else begin
         osc_lvl_d <= osc_lvl;
         if (master_clear_n_active || next_wake) begin
            main_osc_run <= 1'b1;
            io_hold      <= 1'b0;
         end else if (sleep_exec) begin
            main_osc_run <= 1'b0;
            io_hold      <= 1'b1;
         end
      end
   end

   assign global_irq_enable = irq.global_irq_enable;

endmodule : wdsc_core

// *** wdsc_core_assertions.sv ***
// port-level properties of the watchdog and sleep control block
`timescale 1ns/1ps
module wdsc_checker (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // pins
   input wire logic master_clear_n,
   // device control
   input wire logic device_reset,
   input wire logic wake_pulse,
   input wire logic isr_vector_req,
   input wire logic prefetch_next,
   input wire logic main_osc_run,
   input wire logic io_hold,
   input wire logic global_irq_enable,
   // status flags
   input wire logic timeout_flag_n,
   input wire logic powerdown_flag_n
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // a time-out landing on the sleep edge clears the timeout flag and resets the device
   sleep_entry_a: assert property (
      $rose(io_hold) |-> !main_osc_run && !powerdown_flag_n && prefetch_next &&
                         (timeout_flag_n || device_reset))
      else $error("sleep entry side effects missing");
   prefetch_only_a: assert property (
      prefetch_next |-> $rose(io_hold))
      else $error("prefetch without executed sleep");
   wake_clean_a: assert property (
      wake_pulse |-> $fell(io_hold) && main_osc_run && !device_reset)
      else $error("wake without leaving sleep");
   vector_gate_a: assert property (
      isr_vector_req |-> wake_pulse && global_irq_enable)
      else $error("vector without global enable");
   hold_asleep_a: assert property (
      io_hold |-> !main_osc_run && !powerdown_flag_n)
      else $error("oscillator or flag wrong asleep");
   master_clear_n_reset_a: assert property (
      !master_clear_n [*7] |-> device_reset)
      else $error("master clear gave no reset");
   reset_gie_a: assert property (
      device_reset |=> !global_irq_enable)
      else $error("global enable kept over reset");
   timeout_cause_a: assert property (
      $fell(timeout_flag_n) |-> ##[0:1] (device_reset || wake_pulse))
      else $error("timeout flag without reset or wake");
   cover property ($rose(io_hold));
   cover property (isr_vector_req);
   cover property (wake_pulse && !timeout_flag_n);
endmodule : wdsc_checker

// *** test_watchdog_and_sleep_control.sv ***
// self-checking bench for the watchdog and sleep control block
`timescale 1ns/1ps
`include "wdsc_defs.svh"
module test_watchdog_and_sleep_control;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_we = 1'b0;
   logic        reg_re = 1'b0;
   logic [7:0]  reg_rdata;
   logic        clear_watchdog_instr = 1'b0;
   logic        sleep_instr = 1'b0;
   logic        wdt_rc_osc = 1'b0;
   logic        master_clear_n = 1'b1; // idle high; t_fuse_off pulls it low during sleep
   logic        t0_overflow = 1'b0;
   logic        int_pin_event = 1'b0;
   logic        rb_change_event = 1'b0;
   logic [7:0]  periph_irq_req = 8'h00;
   logic [7:0]  periph_clockless = 8'h00;
   logic        t0_source_evt = 1'b0;
   logic        t0_inc, device_reset, wake_pulse, isr_vector_req, prefetch_next;
   logic        main_osc_run, io_hold, global_irq_enable, timeout_flag_n, powerdown_flag_n;
   logic        rc_en = 1'b0;
   logic [2:0]  rc_div = 3'h0;
   logic [1:0]  s;
   int          bad_count = 0;
   int          samples_checked = 0;

   wdsc_core #(.WDT_BASE_TICKS(4)) wdsc_core_inst (
      .mclk, .rst, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
      .clear_watchdog_instr, .sleep_instr, .wdt_rc_osc, .master_clear_n,
      .t0_overflow, .int_pin_event, .rb_change_event, .periph_irq_req,
      .periph_clockless, .t0_source_evt, .t0_inc, .device_reset, .wake_pulse,
      .isr_vector_req, .prefetch_next, .main_osc_run, .io_hold,
      .global_irq_enable, .timeout_flag_n, .powerdown_flag_n
   );

   always #20 mclk = ~mclk;
   // slow oscillator, one tick each 8 clocks, parked low while stopped
   always @(posedge mclk) begin
      rc_div <= rc_div + 3'h1;
      wdt_rc_osc <= rc_en & rc_div[2];
   end

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_we <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_we <= 1'b0;
   endtask : wr

   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_re <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_re <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask : rd

   // stops at the first cycle showing a reset or a wake
   task automatic watch(input int n, output logic [1:0] seen);
      seen = 2'b00;
      for (int i = 0; i < n && seen == 2'b00; i++) begin
         @(posedge mclk);
         #1 seen = {device_reset, wake_pulse};
      end
   endtask : watch

   task automatic sleep_go;
      @(posedge mclk);
      sleep_instr <= 1'b1;
      @(posedge mclk);
      sleep_instr <= 1'b0;
      #1;
   endtask : sleep_go

   task automatic t_regs;
      rd(`WDSC_ADDR_CONFIG, `WDSC_CFG_RESET);
      rd(`WDSC_ADDR_OPTION, `WDSC_OPT_RESET);
      rd(`WDSC_ADDR_IRQCTL, 8'h00);
      rd(`WDSC_ADDR_STATUS, 8'h18);
      wr(`WDSC_ADDR_STATUS, 8'h00);
      rd(`WDSC_ADDR_STATUS, 8'h18);
      rd(16'h0055, 8'h00);
      wr(`WDSC_ADDR_OPTION_HI, 8'h5a);
      rd(`WDSC_ADDR_OPTION, 8'h5a);
   endtask : t_regs

   task automatic t_nop;
      wr(`WDSC_ADDR_IRQCTL, 8'h08);
      @(posedge mclk) rb_change_event <= 1'b1;
      @(posedge mclk) rb_change_event <= 1'b0;
      sleep_go();
      chk(8'({io_hold, prefetch_next, powerdown_flag_n, timeout_flag_n}), 8'h03);
      wr(`WDSC_ADDR_IRQCTL, 8'h00);
   endtask : t_nop

   task automatic t_irq_wake;
      for (int g = 0; g < 2; g++) begin
         wr(`WDSC_ADDR_IRQCTL, {g[0], 7'h10});
         sleep_go();
         chk(8'({io_hold, main_osc_run, prefetch_next,
                 powerdown_flag_n, timeout_flag_n}), 8'h15);
         @(posedge mclk) int_pin_event <= 1'b1;
         @(posedge mclk) int_pin_event <= 1'b0;
         watch(6, s);
         chk(8'(s), 8'h01);
         chk(8'(isr_vector_req), 8'(g[0]));
         rd(`WDSC_ADDR_STATUS, 8'h10);
         wr(`WDSC_ADDR_IRQCTL, 8'h00);
      end
   endtask : t_irq_wake

   // timer0 sees every second event at ratio 0, every event once the watchdog owns the scaler
   task automatic t_t0_scale;
      wr(`WDSC_ADDR_OPTION, 8'h00);
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk) t0_source_evt <= 1'b1;
         @(posedge mclk) t0_source_evt <= 1'b0;
         #1 chk(8'(t0_inc), 8'(i[0]));
      end
      wr(`WDSC_ADDR_OPTION, 8'h08);
      @(posedge mclk) t0_source_evt <= 1'b1;
      @(posedge mclk) t0_source_evt <= 1'b0;
      #1 chk(8'(t0_inc), 8'h01);
   endtask : t_t0_scale

   // clocked sources stay silent asleep; a clockless request wakes without vectoring
   task automatic t_periph_wake;
      wr(`WDSC_ADDR_IRQCTL, 8'h60);
      sleep_go();
      @(posedge mclk);
      t0_overflow    <= 1'b1;
      periph_irq_req <= 8'h01;
      @(posedge mclk) t0_overflow <= 1'b0;
      watch(6, s);
      chk(8'(s), 8'h00);
      @(posedge mclk) periph_clockless <= 8'h01;
      watch(4, s);
      chk(8'({s, isr_vector_req}), 8'h02);
      @(posedge mclk) periph_irq_req <= 8'h00;
      periph_clockless <= 8'h00;
      rd(`WDSC_ADDR_IRQCTL, 8'h60);
      wr(`WDSC_ADDR_IRQCTL, 8'h00);
   endtask : t_periph_wake

   // regular clears hold the time-out off, then it is let run out
   task automatic t_run_out(input logic [7:0] opt, input int lo, input int hi);
      wr(`WDSC_ADDR_OPTION, opt);
      rc_en <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         @(posedge mclk) clear_watchdog_instr <= 1'b1;
         @(posedge mclk) clear_watchdog_instr <= 1'b0;
         watch(18, s);
         chk(8'(s), 8'h00);
      end
      rd(`WDSC_ADDR_OPTION, opt);
      watch(lo, s);
      chk(8'(s), 8'h00);
      watch(hi, s);
      chk(8'(s), 8'h02);
      chk(8'(timeout_flag_n), 8'h00);
      rc_en <= 1'b0;
   endtask : t_run_out

   task automatic t_wdt_wake;
      wr(`WDSC_ADDR_OPTION, 8'h00);
      @(posedge mclk) clear_watchdog_instr <= 1'b1;
      @(posedge mclk) clear_watchdog_instr <= 1'b0;
      sleep_go();
      rc_en <= 1'b1;
      watch(80, s);
      chk(8'(s), 8'h01);
      chk(8'({timeout_flag_n, io_hold, main_osc_run}), 8'h01);
      rc_en <= 1'b0;
   endtask : t_wdt_wake

   task automatic t_fuse_off;
      wr(`WDSC_ADDR_CONFIG, 8'hfb);
      wr(`WDSC_ADDR_IRQCTL, 8'h80);
      sleep_go();
      rc_en <= 1'b1;
      watch(100, s);
      chk(8'(s), 8'h00);
      master_clear_n <= 1'b0;
      watch(12, s);
      chk(8'(s), 8'h02);
      chk(8'({global_irq_enable, io_hold}), 8'h00);
      repeat (3) @(posedge mclk);
      master_clear_n <= 1'b1;
      #1 chk(8'(device_reset), 8'h01);
      rc_en <= 1'b0;
      repeat (8) @(posedge mclk);
   endtask : t_fuse_off

   initial begin
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      t_regs();
      t_t0_scale();
      t_nop();
      t_irq_wake();
      t_periph_wake();
      t_run_out(8'h03, 2, 60);
      t_run_out(8'h09, 28, 60);
      t_wdt_wake();
      t_fuse_off();
      wrap_up();
   end

   initial begin
      repeat (20000) @(posedge mclk);
      bad_count++;
      wrap_up();
   end
endmodule : test_watchdog_and_sleep_control

bind wdsc_core wdsc_checker wdsc_checker_inst (
   .mclk, .rst, .master_clear_n, .device_reset, .wake_pulse, .isr_vector_req,
   .prefetch_next, .main_osc_run, .io_hold, .global_irq_enable,
   .timeout_flag_n, .powerdown_flag_n
);
